// File: core/holiday_match.sv
`timescale 1ns/1ps
module holiday_match
    import sched_pkg::*;
(
    input wire logic [3:0] i_month, // current month
    input wire logic [4:0] i_day,   // current day
    input wire hol_tab_t i_tab,     // holiday table
    output logic [1:0] o_part       // partitions on holiday today
);
    // month 0 marks an empty entry, which never matches a real date
    always_comb
    begin
        o_part = 2'h0;
        for (int i = 0; i < N_HOL; i++)
            if (i_tab[i].mon == i_month && i_tab[i].day == i_day)
                o_part = o_part | i_tab[i].part;
    end
endmodule // holiday_match

// File: core/sched_pkg.sv
package sched_pkg;
    localparam int N_HOL = 16;
    localparam int N_EV = 20;
    localparam int N_WIN = 20;
    // register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_SEL = 8'h08;
    localparam logic [7:0] A_EV = 8'h0C;
    localparam logic [7:0] A_WIN = 8'h10;
    localparam logic [7:0] A_HOL = 8'h14;
    localparam logic [7:0] A_DAYKEY = 8'h18;
    localparam logic [7:0] A_PARTKEY = 8'h1C;
    localparam logic [7:0] A_XXMIN = 8'h20;
    localparam logic [7:0] A_YYSEC = 8'h24;
    localparam logic [7:0] A_HOLIDX = 8'h28;
    // event word: tgt[7:0] act[13:8] mode[18:16] win[23:19] days[31:24]
    localparam int EV_TGT = 0;
    localparam int EV_ACT = 8;
    localparam int EV_MODE = 16;
    localparam int EV_WIN = 19;
    localparam int EV_DAYS = 24;
    // window word: start[10:0] stop[26:16], minutes of day
    localparam int WN_STOP = 16;
    // holiday word: day[4:0] month[11:8] partitions[17:16]
    localparam int HL_MON = 8;
    localparam int HL_PART = 16;
    // action codes
    localparam logic [5:0] ACT_NONE = 6'h00;
    localparam logic [5:0] ACT_RLY_FIRST = 6'h01;
    localparam logic [5:0] ACT_RLY_LAST = 6'h0A;
    localparam logic [5:0] ACT_ARM_FIRST = 6'h14;
    localparam logic [5:0] ACT_ARM_LAST = 6'h18;
    localparam logic [5:0] ACT_BYP = 6'h1E;
    localparam logic [5:0] ACT_UNBYP = 6'h1F;
    localparam logic [5:0] ACT_WIN_FIRST = 6'h28;
    localparam logic [5:0] ACT_WIN_LAST = 6'h2A;
    localparam logic [5:0] ACT_REMIND = 6'h32;
    localparam logic [5:0] ACT_DISARM = 6'h16;
    // activation modes
    localparam logic [2:0] M_START = 3'h1;
    localparam logic [2:0] M_END = 3'h2;
    localparam logic [2:0] M_DURING = 3'h3;
    localparam logic [2:0] M_BOTH = 3'h4;
    // fixed relay pulse, in seconds
    localparam logic [15:0] PULSE_S = 16'h0002;
    localparam logic [15:0] SEC_PER_MIN = 16'h003C;
    localparam logic [7:0] DAYS_ALL = 8'hFF;
    localparam logic [7:0] PARTS_ALL = 8'h03;
    localparam logic [3:0] KEY_ALL = 4'h0;
    typedef struct packed {
        logic [7:0] days;
        logic [4:0] win;
        logic [5:0] act;
        logic [7:0] tgt;
        logic [2:0] mode;
    } ev_s;
    typedef struct packed {
        logic [3:0] mon;
        logic [4:0] day;
        logic [1:0] part;
    } hol_s;
    typedef struct packed {
        logic [10:0] start;
        logic [10:0] stop;
    } win_s;
    typedef hol_s [N_HOL-1:0] hol_tab_t;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_SCAN = 2'h1} scan_e;
endpackage

// File: core/time_event_scheduler.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module time_event_scheduler
    import sched_pkg::*;
(
    input wire logic i_ref_clk,         // 50 MHz clock
    input wire logic i_nrst,            // async reset, active low
    input wire logic [7:0] i_addr,      // register address
    input wire logic [31:0] i_wdata,    // write data
    input wire logic i_wr,              // write strobe
    input wire logic i_rd,              // read strobe
    output logic [31:0] o_rdata,        // read data, cycle after i_rd
    input wire logic i_min_tick,        // one pulse per rtc minute
    input wire logic [10:0] i_minute,   // minute of day
    input wire logic [2:0] i_weekday,   // 0 monday .. 6 sunday
    input wire logic [3:0] i_month,     // rtc month
    input wire logic [4:0] i_day,       // rtc day
    input wire logic i_time_set,        // time or date changed
    input wire logic i_sched_exit,      // scheduling menu left
    input wire logic i_prog_exit,       // program mode left
    input wire logic i_dl_disc,         // downloader disconnected
    input wire logic i_dst_adj,         // daylight saving step
    input wire logic i_fire_offnorm,    // fire off-normal present
    output logic o_act_stb,             // action pulse
    output logic [5:0] o_act_code,      // action code
    output logic [7:0] o_act_tgt,       // relay, group, parts, list
    output logic o_act_on,              // 1 apply, 0 reverse
    output logic [15:0] o_act_dur_s,    // closure seconds, 0 latched
    output logic o_arm_warn,            // auto-arm warning pulse
    output logic o_beep_start,          // keypad reminder pulse
    output logic [1:0] o_sched_lock,    // event holds arming
    output logic [1:0] o_hol_today      // holiday schedule in force
);
    typedef struct packed {
        ev_s [N_EV-1:0] ev;
        win_s [N_WIN-1:0] win;
        hol_tab_t hol;
        logic [7:0] xx_min;
        logic [7:0] yy_sec;
        logic en;
        logic reject;
        logic hol_edit;
        logic [4:0] sel;
        logic [3:0] hol_sel;
        logic [N_EV-1:0] prev;
        scan_e fsm;
        logic [4:0] idx;
        logic refr;
        logic pend_tick;
        logic pend_refr;
        logic [31:0] rdata;
        logic act_stb;
        logic [5:0] act_code;
        logic [7:0] act_tgt;
        logic act_on;
        logic [15:0] act_dur;
        logic arm_warn;
        logic beep;
        logic [1:0] lock;
        logic [1:0] hol_today;
    } st_s;

    st_s st_q;
    st_s st_d;
    ev_s cur_ev;
    win_s cur_win;
    logic in_now;
    logic [1:0] hol_now;

    function automatic logic in_rng(logic [5:0] a, logic [5:0] lo,
                                    logic [5:0] hi);
        return a >= lo && a <= hi;
    endfunction

    function automatic logic is_arm(logic [5:0] a);
        return in_rng(a, ACT_ARM_FIRST, ACT_ARM_LAST);
    endfunction

    // which modes each action may use
    function automatic logic mode_ok(logic [5:0] a, logic [2:0] m);
        logic any;
        logic no4;
        any = m >= M_START && m <= M_BOTH;
        no4 = m >= M_START && m <= M_DURING;
        if (a == ACT_NONE)
            return 1'b1;
        if (in_rng(a, ACT_RLY_FIRST, ACT_RLY_LAST) || a == ACT_REMIND)
            return any;
        if (is_arm(a) || a == ACT_BYP || a == ACT_UNBYP)
            return no4;
        if (in_rng(a, ACT_WIN_FIRST, ACT_WIN_LAST))
            return m == M_DURING;
        return 1'b0;
    endfunction

    // closure length; relay group codes mirror single relay codes
    function automatic logic [15:0] dur_s(logic [5:0] a, logic [7:0] x,
                                          logic [7:0] y);
        logic [5:0] k;
        k = (a > 6'h05) ? 6'(a - 6'h05) : a;
        case (k)
            6'h03: return PULSE_S;
            6'h04: return 16'(x * SEC_PER_MIN);
            6'h05: return {8'h00, y};
            default: return 16'h0000;
        endcase
    endfunction

    // key 0 fills the whole mask, or clears it when already full; key n, up to the count of mask bits, flips bit n-1
    function automatic logic [7:0] key_tog(logic [7:0] m, logic [3:0] k,
                                           logic [7:0] all);
        logic [7:0] r;
        r = m;
        if (k == KEY_ALL)
            r = (m == all) ? 8'h00 : all;
        else if ({4'h0, k} <= 8'(($countones(all))))
            r = m ^ (8'h01 << (k - 4'h1));
        return r;
    endfunction

    assign cur_ev = st_q.ev[st_q.idx];
    assign cur_win = (cur_ev.win == 5'h00) ? '0
                   : st_q.win[cur_ev.win - 5'h01];

    window_check u_win (
        .i_start (cur_win.start),
        .i_stop  (cur_win.stop),
        .i_now   (i_minute),
        .o_in    (in_now)
    );

    holiday_match u_hol (
        .i_month (i_month),
        .i_day   (i_day),
        .i_tab   (st_q.hol),
        .o_part  (hol_now)
    );

    always_comb
    begin
        logic refresh;
        logic ok;
        logic day_ok;
        logic now_on;
        logic st_e;
        logic en_e;
        logic fire;
        logic on;
        ev_s w;
        refresh = 1'b0;
        ok = 1'b0;
        day_ok = 1'b0;
        now_on = 1'b0;
        st_e = 1'b0;
        en_e = 1'b0;
        fire = 1'b0;
        on = 1'b0;
        w = '0;
        st_d = st_q;
        st_d.act_stb = 1'b0;
        st_d.arm_warn = 1'b0;
        st_d.beep = 1'b0;
        st_d.rdata = 32'h0000_0000;
        st_d.hol_today = hol_now;

        // register writes
        if (i_wr)
        begin
            case (i_addr)
                A_CTRL: st_d.en = i_wdata[0];
                A_STAT: if (i_wdata[0]) st_d.reject = 1'b0;
                A_SEL: st_d.sel = i_wdata[4:0];
                A_EV:
                begin
                    w.tgt = i_wdata[EV_TGT +: 8];
                    w.act = i_wdata[EV_ACT +: 6];
                    w.mode = i_wdata[EV_MODE +: 3];
                    w.win = i_wdata[EV_WIN +: 5];
                    w.days = i_wdata[EV_DAYS +: 8];
                    ok = mode_ok(w.act, w.mode) && w.win <= 5'(N_WIN);
                    if (st_q.sel != 5'h00 && st_q.sel <= 5'(N_EV))
                    begin
                        if (ok)
                            st_d.ev[st_q.sel - 5'h01] = w;
                        else
                            st_d.reject = 1'b1;
                    end
                end
                A_WIN:
                    if (st_q.sel != 5'h00 && st_q.sel <= 5'(N_WIN))
                        st_d.win[st_q.sel - 5'h01] =
                            {i_wdata[10:0], i_wdata[WN_STOP +: 11]};
                A_HOL:
                    if (st_q.hol_edit)
                    begin
                        st_d.hol[st_q.hol_sel].day = i_wdata[4:0];
                        st_d.hol[st_q.hol_sel].mon = i_wdata[HL_MON +: 4];
                        st_d.hol[st_q.hol_sel].part =
                            i_wdata[HL_PART +: 2];
                    end
                A_HOLIDX:
                    if (i_wdata[7:0] == 8'h00)
                        st_d.hol_edit = 1'b0;
                    else if (i_wdata[7:0] <= 8'(N_HOL))
                    begin
                        st_d.hol_edit = 1'b1;
                        st_d.hol_sel = 4'(i_wdata[7:0] - 8'h01);
                    end
                A_PARTKEY:
                    if (st_q.hol_edit)
                        st_d.hol[st_q.hol_sel].part = 2'(key_tog(
                            {6'h00, st_q.hol[st_q.hol_sel].part},
                            i_wdata[3:0], PARTS_ALL));
                A_DAYKEY:
                    if (st_q.sel != 5'h00 && st_q.sel <= 5'(N_EV))
                        st_d.ev[st_q.sel - 5'h01].days = key_tog(
                            st_q.ev[st_q.sel - 5'h01].days,
                            i_wdata[3:0], DAYS_ALL);
                A_XXMIN: st_d.xx_min = i_wdata[7:0];
                A_YYSEC: st_d.yy_sec = i_wdata[7:0];
                default: ;
            endcase
        end

        // register reads, answered next cycle; unmapped reads zero
        if (i_rd)
        begin
            case (i_addr)
                A_CTRL: st_d.rdata = {31'h0, st_q.en};
                A_STAT: st_d.rdata = {27'h0, st_q.hol_today,
                    st_q.fsm == ST_SCAN, st_q.hol_edit, st_q.reject};
                A_SEL: st_d.rdata = {27'h0, st_q.sel};
                A_EV:
                    if (st_q.sel != 5'h00 && st_q.sel <= 5'(N_EV))
                    begin
                        w = st_q.ev[st_q.sel - 5'h01];
                        st_d.rdata = {w.days, w.win, w.mode, 2'h0,
                            w.act, w.tgt};
                    end
                A_WIN:
                    if (st_q.sel != 5'h00 && st_q.sel <= 5'(N_WIN))
                        st_d.rdata = {5'h0,
                            st_q.win[st_q.sel - 5'h01].stop, 5'h0,
                            st_q.win[st_q.sel - 5'h01].start};
                A_HOL: st_d.rdata = {14'h0, st_q.hol[st_q.hol_sel].part,
                    4'h0, st_q.hol[st_q.hol_sel].mon, 3'h0,
                    st_q.hol[st_q.hol_sel].day};
                A_HOLIDX: st_d.rdata = st_q.hol_edit ?
                    {27'h0, 5'(st_q.hol_sel) + 5'h01} : 32'h0000_0000;
                A_XXMIN: st_d.rdata = {24'h0, st_q.xx_min};
                A_YYSEC: st_d.rdata = {24'h0, st_q.yy_sec};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end

        // sweep the slots one per cycle
        case (st_q.fsm)
            ST_IDLE:
                if (st_q.pend_refr || st_q.pend_tick)
                begin
                    st_d.fsm = ST_SCAN;
                    st_d.idx = 5'h00;
                    st_d.refr = st_q.pend_refr;
                    st_d.pend_refr = 1'b0;
                    st_d.pend_tick = 1'b0;
                    if (st_q.pend_refr)
                        st_d.lock = 2'h0;
                end
            ST_SCAN:
            begin
                day_ok = cur_ev.days[i_weekday]
                    || (hol_now != 2'h0 && cur_ev.days[7]);
                now_on = st_q.en && cur_ev.win != 5'h00
                    && cur_ev.act != ACT_NONE && day_ok && in_now;
                st_e = now_on && !st_q.prev[st_q.idx];
                en_e = !now_on && st_q.prev[st_q.idx];
                if (st_q.refr)
                begin
                    // only held states are restored on refresh
                    fire = cur_ev.mode == M_DURING;
                    on = now_on;
                end
                else
                begin
                    fire = (st_e && cur_ev.mode != M_END)
                        || (en_e && cur_ev.mode != M_START);
                    on = !(en_e && cur_ev.mode == M_DURING);
                end
                if (cur_ev.act == ACT_REMIND)
                    fire = fire && on && i_fire_offnorm;
                st_d.prev[st_q.idx] = now_on;
                if (fire)
                begin
                    st_d.act_stb = 1'b1;
                    st_d.act_code = cur_ev.act;
                    st_d.act_tgt = cur_ev.tgt;
                    st_d.act_on = on;
                    st_d.act_dur = dur_s(cur_ev.act, st_q.xx_min,
                        st_q.yy_sec);
                    st_d.beep = cur_ev.act == ACT_REMIND;
                    st_d.arm_warn = is_arm(cur_ev.act) && on
                        && cur_ev.act != ACT_DISARM;
                    if (is_arm(cur_ev.act))
                    begin
                        // held against temporary edits and extension
                        if (cur_ev.mode == M_DURING && !on)
                            st_d.lock = st_q.lock & ~cur_ev.tgt[1:0];
                        else
                            st_d.lock = st_q.lock | cur_ev.tgt[1:0];
                    end
                end
                if (st_q.idx == 5'(N_EV - 1))
                    st_d.fsm = ST_IDLE;
                else
                    st_d.idx = st_q.idx + 5'h01;
            end
            default: st_d.fsm = ST_IDLE;
        endcase

        // new triggers win over the clear above
        if (i_min_tick)
            st_d.pend_tick = 1'b1;
        if (i_time_set || i_sched_exit || i_prog_exit || i_dl_disc
            || i_dst_adj)
            st_d.pend_refr = 1'b1;
    end

    // power-up counts as a refresh
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q <= '0;
            st_q.pend_refr <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign o_rdata = st_q.rdata;
    assign o_act_stb = st_q.act_stb;
    assign o_act_code = st_q.act_code;
    assign o_act_tgt = st_q.act_tgt;
    assign o_act_on = st_q.act_on;
    assign o_act_dur_s = st_q.act_dur;
    assign o_arm_warn = st_q.arm_warn;
    assign o_beep_start = st_q.beep;
    assign o_sched_lock = st_q.lock;
    assign o_hol_today = st_q.hol_today;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    chk_beep_fire: assert property (o_beep_start |->
        $past(i_fire_offnorm) && o_act_code == ACT_REMIND)
        else $error("beep without fire off-normal");
    chk_arm_no_mode4: assert property (
        st_q.fsm == ST_SCAN && is_arm(cur_ev.act) |->
        cur_ev.mode != M_BOTH) else $error("arm slot in mode 4");
    chk_win_mode3: assert property (
        st_q.fsm == ST_SCAN && in_rng(cur_ev.act, ACT_WIN_FIRST,
        ACT_WIN_LAST) |-> cur_ev.mode == M_DURING)
        else $error("window action not in mode 3");
    chk_pulse_2s: assert property (
        o_act_stb && (o_act_code == 6'h03 || o_act_code == 6'h08)
        |-> o_act_dur_s == 16'h0002) else $error("pulse not 2 s");
    chk_bad_reject: assert property (
        i_wr && i_addr == A_EV && st_q.sel == 5'h01
        && !mode_ok(i_wdata[13:8], i_wdata[18:16])
        |=> st_q.reject && $stable(st_q.ev[0]))
        else $error("bad event config stored");
    chk_rdata_once: assert property (!$past(i_rd) |->
        o_rdata == 32'h0000_0000) else $error("stale read data");
    chk_refresh_scan: assert property (i_time_set |->
        ##[1:24] st_q.fsm == ST_SCAN && st_q.refr)
        else $error("no refresh sweep");
    chk_hol_quit: assert property (i_wr && i_addr == A_HOLIDX
        && i_wdata[7:0] == 8'h00 |=> !st_q.hol_edit)
        else $error("holiday edit not left");
    chk_warn_arm: assert property (o_arm_warn |->
        o_act_stb && o_act_on && is_arm(o_act_code))
        else $error("warning without arming");
endmodule // time_event_scheduler

// File: core/window_check.sv
`timescale 1ns/1ps
module window_check
    import sched_pkg::*;
(
    input wire logic [10:0] i_start, // window start minute
    input wire logic [10:0] i_stop,  // window stop minute
    input wire logic [10:0] i_now,   // current minute of day
    output logic o_in                // now inside the window
);
    // a start past the stop means the window wraps midnight
    always_comb
    begin
        if (i_start <= i_stop)
            o_in = (i_now >= i_start) && (i_now < i_stop);
        else
            o_in = (i_now >= i_start) || (i_now < i_stop);
    end
endmodule // window_check

// File: testbench/action_sink.sv
`timescale 1ns/1ps
module action_sink
(
    input wire logic i_ref_clk,       // bench clock
    input wire logic i_nrst,          // async reset, active low
    input wire logic i_act_stb,       // action pulse
    input wire logic [5:0] i_act_code, // action code
    input wire logic i_act_on,        // apply or reverse
    input wire logic [15:0] i_act_dur_s, // closure seconds
    input wire logic i_arm_warn,      // auto-arm warning
    input wire logic i_beep_start,    // keypad reminder
    output int o_n_act,               // actions seen
    output int o_n_beep,              // reminders seen
    output logic [23:0] o_last        // warn, on, code, duration
);
    // relays and partitions only log what fired; timing of closures
    // is left to the bench since the block hands out seconds only
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_n_act <= 0;
            o_n_beep <= 0;
            o_last <= 24'h00_0000;
        end
        else if (i_act_stb)
        begin
            o_n_act <= o_n_act + 1;
            o_n_beep <= o_n_beep + int'(i_beep_start);
            o_last <= {i_arm_warn, i_act_on, i_act_code, i_act_dur_s};
        end
    end
endmodule // action_sink

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import sched_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [10:0] minute = 11'h000;
    logic [3:0] month = 4'h0;
    logic [4:0] day = 5'h00;
    logic fire = 1'b0;
    logic [4:0] rsrc = 5'h00; // time, sched, prog, downloader, dst
    logic [2:0] wday = 3'h2;
    logic stb, on, warn, beep;
    logic [5:0] code;
    logic [7:0] tgt;
    logic [15:0] dur;
    logic [1:0] lock, hol;
    logic [23:0] last;
    int n_act, n_beep, n_errors = 0, check_count = 0;
    time_event_scheduler time_event_scheduler_inst (.i_ref_clk(clk),
        .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_min_tick(tick), .i_minute(minute),
        .i_weekday(wday), .i_month(month), .i_day(day),
        .i_time_set(rsrc[0]), .i_sched_exit(rsrc[1]),
        .i_prog_exit(rsrc[2]), .i_dl_disc(rsrc[3]),
        .i_dst_adj(rsrc[4]), .i_fire_offnorm(fire), .o_act_stb(stb),
        .o_act_code(code), .o_act_tgt(tgt), .o_act_on(on),
        .o_act_dur_s(dur), .o_arm_warn(warn), .o_beep_start(beep),
        .o_sched_lock(lock), .o_hol_today(hol));
    action_sink action_sink_inst (.i_ref_clk(clk), .i_nrst(nrst),
        .i_act_stb(stb), .i_act_code(code), .i_act_on(on),
        .i_act_dur_s(dur), .i_arm_warn(warn), .i_beep_start(beep),
        .o_n_act(n_act), .o_n_beep(n_beep), .o_last(last));
    // 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, act, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // a sweep takes 20 cycles, so wait past it before the next trigger
    task automatic min_tick(input logic [10:0] m);
        @(posedge clk);
        minute <= m;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (25) @(posedge clk);
    endtask
    // one refresh pulse on the chosen causes, then wait out the sweep
    task automatic refresh(input logic [4:0] c);
        @(posedge clk);
        rsrc <= c;
        @(posedge clk);
        rsrc <= 5'h00;
        repeat (25) @(posedge clk);
    endtask
    task automatic t_reject();
        rd_chk(A_STAT, 32'h0000_0000);
        rd_chk(8'h3C, 32'h0000_0000);
        wr_reg(A_SEL, 32'h0000_0001);
        wr_reg(A_EV, 32'hFF0C_0305);
        wr_reg(A_EV, 32'hFF0C_1405);
        rd_chk(A_STAT, 32'h0000_0001);
        rd_chk(A_EV, 32'hFF0C_0305);
        wr_reg(A_STAT, 32'h0000_0001);
        wr_reg(A_SEL, 32'h0000_0004);
        wr_reg(A_EV, 32'hFF0C_2800);
        rd_chk(A_STAT, 32'h0000_0001);
        wr_reg(A_STAT, 32'h0000_0001);
    endtask
    task automatic t_pulse();
        wr_reg(A_SEL, 32'h0000_0001);
        wr_reg(A_WIN, 32'h000C_000A);
        wr_reg(A_SEL, 32'h0000_0003);
        wr_reg(A_EV, 32'hFF09_3200);
        wr_reg(A_CTRL, 32'h0000_0001);
        fire <= 1'b1;
        min_tick(11'h009);
        chk(n_act, 0);
        min_tick(11'h00A);
        chk(n_act, 2);
        chk(n_beep, 1);
        min_tick(11'h00C);
        chk(n_act, 3);
        chk(last, {2'b01, 6'h03, PULSE_S});
    endtask
    task automatic t_arm();
        wr_reg(A_SEL, 32'h0000_0002);
        wr_reg(A_WIN, 32'h0016_0014);
        wr_reg(A_EV, 32'hFF13_1503);
        min_tick(11'h014);
        chk(last, {2'b11, 6'h15, 16'h0000});
        chk(tgt, 32'h0000_0003);
        chk(lock, 2'b11);
        refresh(5'h02);
        chk(n_act, 5);
        min_tick(11'h016);
        chk(last[22:16], {1'b0, 6'h15});
        chk(lock, 2'b00);
    endtask
    // group minutes, relay seconds, weekday gate, day keys, refresh
    task automatic t_dur();
        wr_reg(A_XXMIN, 32'h0000_0003);
        wr_reg(A_YYSEC, 32'h0000_002D);
        wr_reg(A_SEL, 32'h0000_0005);
        wr_reg(A_WIN, 32'h0020_001E);
        wr_reg(A_EV, 32'hFF29_0907);
        wr_reg(A_SEL, 32'h0000_0006);
        wr_reg(A_EV, 32'hFB29_0501);
        min_tick(11'h01E);
        chk(n_act, 7);
        chk(last, {2'b01, 6'h09, 16'h00B4});
        wday <= 3'h3;
        min_tick(11'h01F);
        chk(n_act, 8);
        chk(last, {2'b01, 6'h05, 16'h002D});
        wr_reg(A_DAYKEY, 32'h0000_0000);
        rd_chk(A_EV, 32'hFF29_0501);
        refresh(5'h1D);
        chk(n_act, 9);
        chk(last, {2'b00, 6'h15, 16'h0000});
        chk(lock, 2'b00);
    endtask
    task automatic t_hol();
        wr_reg(A_HOLIDX, 32'h0000_0001);
        rd_chk(A_STAT, 32'h0000_0002);
        wr_reg(A_HOL, 32'h0000_0704);
        wr_reg(A_PARTKEY, 32'h0000_0001);
        rd_chk(A_HOL, 32'h0001_0704);
        wr_reg(A_PARTKEY, 32'h0000_0000);
        rd_chk(A_HOL, 32'h0003_0704);
        wr_reg(A_HOLIDX, 32'h0000_0000);
        rd_chk(A_STAT, 32'h0000_0000);
        month <= 4'h7;
        day <= 5'h04;
        repeat (4) @(posedge clk);
        chk(hol, 2'b11);
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    initial
    begin
        #200us n_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (25) @(posedge clk);
        t_reject();
        t_pulse();
        t_arm();
        t_dur();
        t_hol();
        end_of_test();
    end
endmodule // testbench
